// ### logic/mcp_pkg.sv
package mcp_pkg;

    // ****************************************
    // bus map
    // ****************************************
    localparam int MCP_AW = 8; // apb address width
    localparam logic [7:0] MCP_A_CTRL = 8'h00; // timebase control
    localparam logic [7:0] MCP_A_PER = 8'h04; // timebase_period_value
    localparam logic [7:0] MCP_A_DUTY = 8'h08; // duty i at +stride*i
    localparam logic [7:0] MCP_A_DEAD = 8'h18; // dead times
    localparam logic [7:0] MCP_A_OVRD = 8'h1c; // manual override
    localparam logic [7:0] MCP_A_FLT = 8'h20; // fault setup
    localparam logic [7:0] MCP_A_PINEN = 8'h24; // pin enables
    localparam logic [7:0] MCP_A_TRIG = 8'h28; // a/d trigger point
    localparam logic [7:0] MCP_A_STAT = 8'h2c; // live state, read only
    localparam logic [7:0] MCP_A_EVT = 8'h30; // sticky events, w1c
    localparam logic [7:0] MCP_STRIDE = 8'h04; // one word per register

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int MCP_CW = 15; // timebase width
    localparam int MCP_DW = 16; // duty in half cycles
    localparam int MCP_DTW = 8; // dead time width
    localparam logic [14:0] MCP_PER_RST = 15'h00ff;
    localparam int MCP_EVT_PER = 0; // postscaled period event
    localparam int MCP_EVT_TRG = 1; // a/d trigger seen
    localparam int MCP_EVT_FLT = 2; // fault clear bits 3:2
    localparam int MCP_TRG_DIR = 15; // trigger direction bit

    // prescaler limits for divide by 1, 4, 16, 64
    localparam logic [5:0] MCP_PRE_1 = 6'h00;
    localparam logic [5:0] MCP_PRE_4 = 6'h03;
    localparam logic [5:0] MCP_PRE_16 = 6'h0f;
    localparam logic [5:0] MCP_PRE_64 = 6'h3f;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        MCP_M_FREE = 2'h0,
        MCP_M_SHOT = 2'h1,
        MCP_M_UPDN = 2'h2,
        MCP_M_UPDN2 = 2'h3
    } mcp_mode_type;

    typedef struct packed {
        logic [3:0] indep; // pair runs independent
        logic [3:0] post; // postscale minus one
        logic [1:0] pre; // prescale select
        mcp_mode_type mode;
        logic en; // timebase running
    } mcp_ctrl_type;

    typedef struct packed {
        logic [3:0] sel; // pair uses second value
        logic [7:0] d1;
        logic [7:0] d0;
    } mcp_dead_type;

    typedef struct packed {
        logic [7:0] val; // forced active levels
        logic [7:0] en;
    } mcp_ovrd_type;

    typedef struct packed {
        logic [7:0] lvl; // pin levels under fault
        logic [1:0] cyc; // 1: cycle by cycle, 0: latched
        logic [1:0] en;
    } mcp_flt_type;

    // prescaler terminal count
    function automatic logic [5:0] mcp_presc_lim(input logic [1:0] sel);
        case (sel)
            2'h0: mcp_presc_lim = MCP_PRE_1;
            2'h1: mcp_presc_lim = MCP_PRE_4;
            2'h2: mcp_presc_lim = MCP_PRE_16;
            default: mcp_presc_lim = MCP_PRE_64;
        endcase
    endfunction : mcp_presc_lim

endpackage : mcp_pkg

// ### logic/mcp_top.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps

// Operation
// - 15-bit timebase with prescaler and postscaler
// - four timebase modes
// - up/down counting gives center-aligned pulses
// - double-update mode loads duty at both ends
// - single-shot runs one period then stops
// - edges placed on half-cycle boundaries
// - each duty generator owns a pin pair
// - pair complementary or independent
// - complementary pairs get hardware dead time
// - pin polarity from fixed configuration inputs
// - software override forces single pins
// - fault inputs force programmed pin levels
// - timebase-aligned a/d trigger pulse
// - each pin enabled or released alone
// - large variant: four pairs, two faults
// - small variant: three pairs
// - center mode runs at half frequency
// - edge, center, double, single-event outputs
module mcp_top #(
    parameter int NUM_PAIRS = 4 // 4 or 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mcp_pkg::MCP_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] fault_in,
    input wire logic cfg_pol_hi,
    input wire logic cfg_pol_lo,
    output logic [2*NUM_PAIRS-1:0] pwm_first,
    output logic [2*NUM_PAIRS-1:0] pwm_second,
    output logic [2*NUM_PAIRS-1:0] pwm_oe,
    output logic adc_trig
);
    import mcp_pkg::*;

    localparam int NP = 2 * NUM_PAIRS; // pin count

    // ****************************************
    // registers
    // ****************************************
    mcp_ctrl_type ctrl_reg;
    logic [MCP_CW-1:0] per_reg; // timebase_period_value
    logic [MCP_DW-1:0] duty_shd_reg [NUM_PAIRS]; // software copy
    logic [MCP_DW-1:0] duty_act_reg [NUM_PAIRS]; // in use
    mcp_dead_type dead_reg;
    mcp_ovrd_type ovrd_reg;
    mcp_flt_type flt_reg;
    logic [7:0] pinen_reg;
    logic [MCP_CW:0] trig_reg; // value plus direction
    logic [1:0] evt_reg; // sticky events
    logic [1:0] fault_st_reg; // fault seen
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [NP-1:0] pwm_first_reg;
    logic [NP-1:0] pwm_second_reg;
    logic [NP-1:0] pwm_oe_reg;
    logic adc_trig_reg;

    // timebase state
    logic [5:0] presc_reg;
    logic [MCP_CW-1:0] cnt_reg;
    logic down_reg; // counting down
    logic [3:0] post_reg;
    logic [MCP_DTW-1:0] dcnt_reg [NUM_PAIRS];
    logic [NUM_PAIRS-1:0] last_reg; // settled raw level

    // ****************************************
    // apb slave
    // ****************************************
    logic acc; // first access cycle
    logic wr; // write lands this edge
    logic [31:0] rd_next;
    logic hit_next;

    assign acc = psel & penable & ~pready_reg;
    assign wr = psel & penable & pready_reg & pwrite;

    // one wait state, then ready
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= acc;
            if (acc) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
                pslverr_reg <= ~hit_next; // unmapped address
            end
        end
    end

    // read mux and decode
    always_comb begin
        rd_next = 32'h0000_0000;
        hit_next = 1'b1;
        case (paddr)
            MCP_A_CTRL: rd_next = 32'(ctrl_reg);
            MCP_A_PER: rd_next = 32'(per_reg);
            MCP_A_DEAD: rd_next = 32'(dead_reg);
            MCP_A_OVRD: rd_next = 32'(ovrd_reg);
            MCP_A_FLT: rd_next = 32'(flt_reg);
            MCP_A_PINEN: rd_next = 32'(pinen_reg);
            MCP_A_TRIG: rd_next = 32'(trig_reg);
            MCP_A_STAT: rd_next = 32'({fault_st_reg, down_reg, ctrl_reg.en, cnt_reg});
            MCP_A_EVT: rd_next = 32'(evt_reg);
            default: hit_next = 1'b0;
        endcase
        for (int i = 0; i < NUM_PAIRS; i++) begin
            if (paddr == MCP_A_DUTY + 8'(i) * MCP_STRIDE) begin
                rd_next = 32'(duty_shd_reg[i]);
                hit_next = 1'b1;
            end
        end
    end

    // ****************************************
    // timebase
    // ****************************************
    logic tick; // prescaled count step
    logic top_hit;
    logic bot_hit;
    logic edge_mode;
    logic upd; // duty load point
    logic shot_end;

    assign edge_mode = (ctrl_reg.mode == MCP_M_FREE) || (ctrl_reg.mode == MCP_M_SHOT);
    assign tick = ctrl_reg.en && (presc_reg == mcp_presc_lim(ctrl_reg.pre));
    assign top_hit = tick && !down_reg && (cnt_reg >= per_reg);
    assign bot_hit = tick && down_reg && (cnt_reg == '0);
    // double update also loads at the bottom turn
    assign upd = top_hit || (bot_hit && ctrl_reg.mode == MCP_M_UPDN2);
    assign shot_end = top_hit && (ctrl_reg.mode == MCP_M_SHOT);

    // prescaler divides the clock
    always_ff @(posedge clk) begin
        if (!rst_n || !ctrl_reg.en || tick) begin
            presc_reg <= 6'h00;
        end else begin
            presc_reg <= presc_reg + 6'h01;
        end
    end

    // counter; up/down covers the period twice, so half rate
    always_ff @(posedge clk) begin
        if (!rst_n || !ctrl_reg.en) begin
            cnt_reg <= '0;
            down_reg <= 1'b0;
        end else if (tick) begin
            if (edge_mode) begin
                // wrap to zero with a period event
                cnt_reg <= top_hit ? '0 : cnt_reg + 15'h0001;
            end else if (!down_reg) begin
                if (top_hit && per_reg != '0) begin
                    down_reg <= 1'b1;
                    cnt_reg <= cnt_reg - 15'h0001;
                end else if (!top_hit) begin
                    cnt_reg <= cnt_reg + 15'h0001;
                end
            end else if (bot_hit) begin
                down_reg <= 1'b0;
                cnt_reg <= (per_reg == '0) ? '0 : 15'h0001;
            end else begin
                cnt_reg <= cnt_reg - 15'h0001;
            end
        end
    end

    // postscaler on period events
    always_ff @(posedge clk) begin
        if (!rst_n || !ctrl_reg.en) begin
            post_reg <= 4'h0;
        end else if (upd) begin
            post_reg <= (post_reg == ctrl_reg.post) ? 4'h0 : post_reg + 4'h1;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg <= '0;
            per_reg <= MCP_PER_RST;
            dead_reg <= '0;
            ovrd_reg <= '0;
            flt_reg <= '0;
            pinen_reg <= 8'h00; // all pins released
            trig_reg <= '0;
        end else begin
            if (wr && paddr == MCP_A_CTRL) begin
                ctrl_reg <= mcp_ctrl_type'(pwdata[$bits(mcp_ctrl_type)-1:0]);
            end else if (shot_end) begin
                ctrl_reg.en <= 1'b0;
            end
            if (wr && paddr == MCP_A_PER) per_reg <= pwdata[MCP_CW-1:0];
            if (wr && paddr == MCP_A_DEAD) begin
                dead_reg <= mcp_dead_type'(pwdata[$bits(mcp_dead_type)-1:0]);
            end
            if (wr && paddr == MCP_A_OVRD) begin
                ovrd_reg <= mcp_ovrd_type'(pwdata[$bits(mcp_ovrd_type)-1:0]);
            end
            if (wr && paddr == MCP_A_FLT) begin
                flt_reg <= mcp_flt_type'(pwdata[$bits(mcp_flt_type)-1:0]);
            end
            if (wr && paddr == MCP_A_PINEN) pinen_reg <= pwdata[7:0];
            if (wr && paddr == MCP_A_TRIG) trig_reg <= pwdata[MCP_CW:0];
        end
    end

    // duty: shadow from bus, active at load points
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_PAIRS; i++) begin
            if (!rst_n) begin
                duty_shd_reg[i] <= '0;
                duty_act_reg[i] <= '0;
            end else begin
                if (wr && paddr == MCP_A_DUTY + 8'(i) * MCP_STRIDE) begin
                    duty_shd_reg[i] <= pwdata[MCP_DW-1:0];
                end
                // stopped timebase takes new duty at once
                if (upd || !ctrl_reg.en) duty_act_reg[i] <= duty_shd_reg[i];
            end
        end
    end

    // ****************************************
    // faults and events
    // ****************************************
    logic [1:0] flt_now;
    logic fault_act;
    logic trig_hit;

    assign flt_now = fault_in & flt_reg.en;
    assign fault_act = |(flt_now | fault_st_reg);

    // latched clears by software, cycle mode at period; set wins
    always_ff @(posedge clk) begin
        for (int f = 0; f < 2; f++) begin
            if (!rst_n) begin
                fault_st_reg[f] <= 1'b0;
            end else if (flt_now[f]) begin
                fault_st_reg[f] <= 1'b1;
            end else if (flt_reg.cyc[f] ? upd : (wr && paddr == MCP_A_EVT
                         && pwdata[MCP_EVT_FLT+f])) begin
                fault_st_reg[f] <= 1'b0;
            end
        end
    end

    // in up/down modes the trigger picks a direction
    assign trig_hit = tick && cnt_reg == trig_reg[MCP_CW-1:0]
                      && (edge_mode || down_reg == trig_reg[MCP_TRG_DIR]);

    // sticky events, set beats clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evt_reg <= 2'h0;
            adc_trig_reg <= 1'b0;
        end else begin
            adc_trig_reg <= trig_hit;
            for (int e = 0; e < 2; e++) begin
                if ((e == MCP_EVT_PER) ? (upd && post_reg == ctrl_reg.post) : trig_hit) begin
                    evt_reg[e] <= 1'b1;
                end else if (wr && paddr == MCP_A_EVT && pwdata[e]) begin
                    evt_reg[e] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // duty compare and dead time
    // ****************************************
    logic [NP-1:0] gen_f; // generated level, first half
    logic [NP-1:0] gen_s; // second half
    logic [NUM_PAIRS-1:0] raw_s_w;
    logic [MCP_DTW-1:0] dnext [NUM_PAIRS];

    // half-cycle index; order swaps when counting down
    always_comb begin
        logic [MCP_DW-1:0] h_f;
        logic [MCP_DW-1:0] h_s;
        logic raw_f;
        logic raw_s;
        logic trans;
        logic blk;
        logic [MCP_DTW-1:0] dsel;
        h_f = {cnt_reg, down_reg};
        h_s = {cnt_reg, ~down_reg};
        raw_f = 1'b0;
        raw_s = 1'b0;
        trans = 1'b0;
        blk = 1'b0;
        dsel = '0;
        gen_f = '0;
        gen_s = '0;
        raw_s_w = '0;
        for (int i = 0; i < NUM_PAIRS; i++) begin
            raw_f = ctrl_reg.en && (h_f < duty_act_reg[i]);
            raw_s = ctrl_reg.en && (h_s < duty_act_reg[i]);
            raw_s_w[i] = raw_s;
            dsel = dead_reg.sel[i] ? dead_reg.d1 : dead_reg.d0;
            trans = raw_s != last_reg[i];
            blk = (trans && dsel != '0) || dcnt_reg[i] != '0;
            dnext[i] = (trans && dsel != '0) ? dsel - 8'h01 :
                       (dcnt_reg[i] != '0) ? dcnt_reg[i] - 8'h01 : '0;
            if (ctrl_reg.indep[i]) begin
                gen_f[2*i] = raw_f;
                gen_s[2*i] = raw_s;
                gen_f[2*i+1] = raw_f;
                gen_s[2*i+1] = raw_s;
            end else begin
                // only the side turning on waits
                gen_f[2*i] = raw_f && !(blk && raw_s);
                gen_s[2*i] = raw_s && !(blk && raw_s);
                gen_f[2*i+1] = !raw_f && !(blk && !raw_s);
                gen_s[2*i+1] = !raw_s && !(blk && !raw_s);
            end
        end
    end

    // dead counters per pair
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_PAIRS; i++) begin
            if (!rst_n) begin
                dcnt_reg[i] <= '0;
                last_reg[i] <= 1'b0;
            end else begin
                dcnt_reg[i] <= dnext[i];
                last_reg[i] <= raw_s_w[i];
            end
        end
    end

    // ****************************************
    // pin stage: fault, override, polarity, enable
    // ****************************************
    always_ff @(posedge clk) begin
        for (int p = 0; p < NP; p++) begin
            logic act_f;
            logic act_s;
            logic pol;
            pol = p[0] ? cfg_pol_lo : cfg_pol_hi;
            if (fault_act) begin
                act_f = flt_reg.lvl[p];
                act_s = flt_reg.lvl[p];
            end else if (ovrd_reg.en[p]) begin
                act_f = ovrd_reg.val[p];
                act_s = ovrd_reg.val[p];
            end else begin
                act_f = gen_f[p];
                act_s = gen_s[p];
            end
            if (!rst_n) begin
                pwm_first_reg[p] <= 1'b0;
                pwm_second_reg[p] <= 1'b0;
                pwm_oe_reg[p] <= 1'b0;
            end else begin
                pwm_first_reg[p] <= pinen_reg[p] & (act_f ~^ pol);
                pwm_second_reg[p] <= pinen_reg[p] & (act_s ~^ pol);
                pwm_oe_reg[p] <= pinen_reg[p];
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pwm_first = pwm_first_reg;
    assign pwm_second = pwm_second_reg;
    assign pwm_oe = pwm_oe_reg;
    assign adc_trig = adc_trig_reg;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_step;
        tick && edge_mode && cnt_reg < per_reg |=> cnt_reg == $past(cnt_reg) + 15'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count did not step");

    property p_wrap;
        top_hit && ctrl_reg.mode == MCP_M_FREE |=> cnt_reg == '0 && ctrl_reg.en;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap at period");

    property p_shot;
        shot_end && !wr |=> !ctrl_reg.en ##1 cnt_reg == '0;
    endproperty
    a_shot: assert property (p_shot) else $error("single shot kept running");

    property p_turn;
        top_hit && !edge_mode && per_reg != '0 |=> down_reg;
    endproperty
    a_turn: assert property (p_turn) else $error("no turn at top");

    property p_dbl;
        bot_hit && ctrl_reg.mode == MCP_M_UPDN2 |=>
            duty_act_reg[0] == $past(duty_shd_reg[0]);
    endproperty
    a_dbl: assert property (p_dbl) else $error("no load at bottom");

    property p_dead;
        !ctrl_reg.indep[0] && !fault_act && ovrd_reg.en[1:0] == 2'h0
            |-> !(gen_f[0] && gen_f[1]) && !(gen_s[0] && gen_s[1]);
    endproperty
    a_dead: assert property (p_dead) else $error("pair overlap");

    property p_pinen;
        !pinen_reg[0] |=> !pwm_oe[0] && !pwm_first[0] && !pwm_second[0];
    endproperty
    a_pinen: assert property (p_pinen) else $error("released pin driven");

    property p_fault;
        flt_now[0] && pinen_reg[0] && $stable(cfg_pol_hi) |=>
            pwm_first[0] == ($past(flt_reg.lvl[0]) ~^ cfg_pol_hi);
    endproperty
    a_fault: assert property (p_fault) else $error("fault level missing");

    property p_trig;
        trig_hit |=> adc_trig ##1 !adc_trig;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger not one pulse");

    c_wrap: cover property (top_hit && ctrl_reg.mode == MCP_M_FREE);
    c_center: cover property (bot_hit && ctrl_reg.mode == MCP_M_UPDN2);
    c_fault: cover property (fault_act && pinen_reg != 8'h00);
    c_dead: cover property (dcnt_reg[0] != '0);

endmodule : mcp_top

// ### verification/mcp_stage_model.sv
`timescale 1ns/1ps
// ****
// power stage and fault sensor model
// ****
module mcp_stage_model (
    input wire logic clk,
    input wire logic [7:0] pwm_first,
    input wire logic [7:0] pwm_second,
    input wire logic [7:0] pwm_oe,
    input wire logic [1:0] trip, // bench asks for a fault
    input wire logic watch, // pairs run complementary
    output logic [1:0] fault_in,
    output int overlap
);
    // sensor level follows the trip request, no filtering
    assign fault_in = trip;
    // both switches of one leg on at once would short the rail
    initial overlap = 0;
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (watch && pwm_oe[2*i] && pwm_oe[2*i+1] &&
                ((pwm_first[2*i] && pwm_first[2*i+1]) ||
                 (pwm_second[2*i] && pwm_second[2*i+1]))) begin
                overlap <= overlap + 1;
            end
        end
    end
endmodule : mcp_stage_model

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import mcp_pkg::*;
    // ****
    // signals
    // ****
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, adc_trig, err, watch;
    logic cfg_pol_hi, cfg_pol_lo;
    logic [MCP_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] fault_in, trip;
    logic [7:0] pwm_first, pwm_second, pwm_oe;
    int fails, n_tests, cyc, n, k, overlap;
    typedef struct {logic [31:0] ctrl; int per;} mcp_row_type;
    // period setting 9: free 10, /4 gives 40, up/down 18
    mcp_row_type rows[4] = '{'{32'h1e01, 10}, '{32'h1e09, 40},
                             '{32'h1e05, 18}, '{32'h1e07, 18}};
    mcp_top mcp_top_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fault_in, .cfg_pol_hi, .cfg_pol_lo,
        .pwm_first, .pwm_second, .pwm_oe, .adc_trig);
    mcp_stage_model mcp_stage_model_i (.clk, .pwm_first, .pwm_second, .pwm_oe,
        .trip, .watch, .fault_in, .overlap);
    // ****
    // tasks
    // ****
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one apb transfer; data taken at the edge that sees pready high, released right after it
    // no wait limit here: only the bench timeout ends a hung transfer
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // cycles up to the next rise of the first high side pin
    task rise;
        do begin @(negedge clk); n++; end while (pwm_first[0] !== 1'b0 && n < 500);
        do begin @(negedge clk); n++; end while (pwm_first[0] !== 1'b1 && n < 500);
    endtask : rise
    // active half cycles of one pin over a window
    task halves(input int c, input int pin);
        n = 0;
        // a register write needs one more edge to reach the pins
        @(posedge clk);
        repeat (c) begin
            @(negedge clk);
            n += pwm_first[pin] + pwm_second[pin];
        end
    endtask : halves
    task print_verdict;
        $display("fails %0d tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // ****
    // clock, timeout
    // ****
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // whole run needs well under 3000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        {psel, penable, pwrite, paddr, pwdata, trip, watch} = '0;
        {cfg_pol_hi, cfg_pol_lo} = 2'h3;
        rst_n = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check("rst_pins", {pwm_first, pwm_second, pwm_oe, adc_trig}, 0);
        check("width", $bits(pwm_first), 8);
        apb(0, MCP_A_PER, 0);
        check("per_rst", rd, 32'h00ff);
        apb(0, 8'h40, 0);
        check("unmapped_rd", rd, 0);
        check("unmapped_err", err, 1);
        apb(1, MCP_A_PER, 9);
        apb(1, MCP_A_DUTY, 4);
        apb(1, MCP_A_PINEN, 8'hff);
        foreach (rows[i]) begin
            apb(1, MCP_A_CTRL, rows[i].ctrl);
            rise();
            rise();
            n = 0;
            rise();
            check("period", n, rows[i].per);
        end
        apb(1, MCP_A_CTRL, 32'h1e01);
        apb(1, MCP_A_DUTY, 7);
        apb(1, MCP_A_TRIG, 3);
        halves(20, 0);
        halves(10, 0);
        check("duty", n, 7);
        k = 0;
        repeat (30) begin @(negedge clk); k += adc_trig; end
        check("trig", k, 3);
        apb(0, MCP_A_EVT, 0);
        check("evt", rd[1:0], 2'h3);
        apb(1, MCP_A_OVRD, 32'h0101);
        halves(10, 0);
        check("ovrd1", n, 20);
        @(posedge clk) cfg_pol_hi <= 1'b0;
        halves(10, 0);
        check("pol", n, 0);
        @(posedge clk) cfg_pol_hi <= 1'b1;
        apb(1, MCP_A_OVRD, 32'h0001);
        halves(10, 0);
        check("ovrd0", n, 0);
        apb(1, MCP_A_OVRD, 0);
        apb(1, MCP_A_FLT, 32'h1);
        @(posedge clk) trip <= 2'h1;
        repeat (3) @(posedge clk);
        trip <= 2'h0;
        halves(10, 0);
        check("flt_pin", n, 0);
        apb(0, MCP_A_STAT, 0);
        check("flt_st", rd[17], 1);
        apb(1, MCP_A_EVT, 32'h4);
        halves(10, 0);
        halves(10, 0);
        check("flt_clr", n, 7);
        // cycle-by-cycle fault: clears itself at the next period
        apb(1, MCP_A_FLT, 32'h5);
        @(posedge clk) trip <= 2'h1;
        repeat (3) @(posedge clk);
        trip <= 2'h0;
        halves(10, 0);
        halves(10, 0);
        check("flt_cyc", n, 7);
        // complementary pair with two cycles of dead time
        apb(1, MCP_A_DEAD, 32'h2);
        apb(1, MCP_A_CTRL, 32'h0001);
        @(posedge clk) watch <= 1'b1;
        halves(20, 0);
        halves(10, 0);
        check("overlap", overlap, 0);
        // seven active halves less two cycles of dead time
        check("dead_hi", n, 3);
        halves(10, 1);
        check("lo_runs", n > 0, 1);
        @(posedge clk) watch <= 1'b0;
        apb(1, MCP_A_CTRL, 32'h1e03);
        repeat (30) @(posedge clk);
        apb(0, MCP_A_CTRL, 0);
        check("shot_stop", rd[2:0], 3'h2);
        apb(1, MCP_A_PINEN, 8'h01);
        repeat (2) @(negedge clk);
        check("pinen", pwm_oe, 8'h01);
        // reset in mid-run: pins released, period back to its reset value
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("rst_mid", {pwm_first, pwm_second, pwm_oe, adc_trig}, 0);
        apb(0, MCP_A_PER, 0);
        check("rst_per", rd, 32'(MCP_PER_RST));
        print_verdict();
    end
endmodule : testbench
